// file: disp_mem.sv
// Single-port display memory with registered read data
`default_nettype none
module disp_mem #(
  parameter int AW = 7,
  parameter int DW = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  disp_mem_if.mem bus
);
  localparam int DEPTH = 1 << AW;

  // Two-state store: unwritten words read as zero in simulation instead of
  // flooding the refresh path with unknowns; real cells power up at random
  bit [DW-1:0] store [DEPTH];
  logic [DW-1:0] rdata_q;

  // Contents are not reset; software loads them after power-up
  always_ff @(posedge clk) begin
    if (bus.we) begin
      store[bus.addr] <= bus.wdata;
    end
  end

  // Read before write: a port that writes sees the old word
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= '0;
    end else begin
      rdata_q <= store[bus.addr];
    end
  end

  assign bus.rdata = rdata_q;
endmodule
`default_nettype wire

// file: disp_mem_if.sv
// Port bundle between the refresh controller and one display memory
`default_nettype none
interface disp_mem_if #(
  parameter int AW = 7,
  parameter int DW = 8
);
  logic we;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW-1:0] rdata;

  modport ctrl (output we, output addr, output wdata, input rdata);
  modport mem (input we, input addr, input wdata, output rdata);
endinterface
`default_nettype wire

// file: font_rom_model.sv
// Font ROM stand-in that answers one edge after each address change
`default_nettype none
module font_rom_model (
  input wire logic clk,
  input wire logic [11:0] addr,
  output logic [4:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  // One register: a design that samples a cycle early still sees the old dots
  always_ff @(posedge clk) begin
    data <= addr[4:0] ^ addr[11:7];
  end
endmodule
`default_nettype wire

// file: glyph_disp_pkg.sv
// Shared constants and types for the character display refresh block
`default_nettype none
package glyph_disp_pkg;
  localparam int SEG_N = 100;
  localparam int COM_N = 16;
  localparam int DOT_W = 5;
  localparam int TEXT_AW = 7;
  localparam int GLYPH_AW = 6;
  localparam int CODE_W = 8;
  localparam int ROW_W = 4;
  localparam int ROM_AW = CODE_W + ROW_W;
  localparam logic [6:0] LINE2_BASE = 7'h40;
  localparam logic [6:0] LINE1_BASE = 7'h00;
  localparam logic [4:0] CHAR_LAST = 5'h13;
  localparam logic [4:0] ROWS_SHORT = 5'h08;
  localparam logic [4:0] ROWS_TALL = 5'h0B;
  localparam logic [4:0] ROWS_TWO = 5'h10;
  localparam logic [3:0] CUR_ROW_SHORT = 4'h7;
  localparam logic [3:0] CUR_ROW_TALL = 4'hA;
  localparam logic [4:0] DOTS_FULL = 5'h1F;
  localparam logic [4:0] DOTS_NONE = 5'h00;
  localparam logic [3:0] GLYPH_PAGE = 4'h0;
  localparam int BLINK_FRAMES = 32;
  localparam logic SLOT_HOST = 1'b0;
  localparam logic SLOT_REFRESH = 1'b1;

  typedef enum logic [1:0] {
    ST_TEXT = 2'b00,
    ST_GLYPH = 2'b01,
    ST_COMPOSE = 2'b10,
    ST_LATCH = 2'b11
  } refresh_state_t;
endpackage
`default_nettype wire

// file: glyph_disp_top.sv
// Character refresh, user glyph lookup, cursor merge and common scan
`default_nettype none
module glyph_disp_top #(
  parameter int BLINK_FRAMES = glyph_disp_pkg::BLINK_FRAMES
) (
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic HOST_PTR_WE,
  input wire logic HOST_PTR_GLYPH,
  input wire logic [6:0] HOST_PTR_ADDR,
  input wire logic HOST_WE,
  input wire logic [7:0] HOST_DATA,
  output logic HOST_READY,
  output logic [6:0] HOST_PTR,
  input wire logic FONT_TALL,
  input wire logic TWO_LINE,
  input wire logic DISPLAY_ON,
  input wire logic CURSOR_ON,
  input wire logic BLINK_ON,
  output logic [11:0] FONT_ROM_ADDR,
  input wire logic [4:0] FONT_ROM_DATA,
  output logic [15:0] COM,
  output logic [99:0] SEG
);
  disp_mem_if #(.AW(glyph_disp_pkg::TEXT_AW), .DW(glyph_disp_pkg::CODE_W)) text_bus ();
  disp_mem_if #(.AW(glyph_disp_pkg::GLYPH_AW), .DW(glyph_disp_pkg::CODE_W)) glyph_bus ();

  disp_mem #(.AW(glyph_disp_pkg::TEXT_AW), .DW(glyph_disp_pkg::CODE_W)) text_code_ram (
    .clk(CLK),
    .rst_n(RST_N),
    .bus(text_bus)
  );

  // Four tall or eight short patterns share the same 64 words
  disp_mem #(.AW(glyph_disp_pkg::GLYPH_AW), .DW(glyph_disp_pkg::CODE_W)) user_glyph_ram (
    .clk(CLK),
    .rst_n(RST_N),
    .bus(glyph_bus)
  );

  logic slot_q;
  logic host_pend_q;
  logic [7:0] pend_data_q;
  logic [6:0] address_pointer_q;
  logic ptr_glyph_q;
  glyph_disp_pkg::refresh_state_t state_q;
  logic [4:0] char_q;
  logic [3:0] row_q;
  logic [7:0] code_q;
  logic [7:0] glyph_q;
  logic [11:0] rom_addr_q;
  logic [99:0] row_buf_q;
  logic [99:0] seg_q;
  logic [15:0] com_q;
  logic [7:0] frame_cnt_q;
  logic blink_q;

  logic commit;
  logic refresh_slot;
  logic [6:0] line_base;
  logic [6:0] text_addr;
  logic [3:0] glyph_row;
  logic [5:0] glyph_addr;
  logic [4:0] num_rows;
  logic row_last;
  logic [3:0] cursor_row;
  logic glyph_code;
  logic at_cursor;
  logic [4:0] src_dots;
  logic [4:0] dots_d;

  assign refresh_slot = (slot_q == glyph_disp_pkg::SLOT_REFRESH);
  assign commit = host_pend_q && !refresh_slot;
  assign HOST_READY = !host_pend_q;
  assign HOST_PTR = address_pointer_q;

  // Slots alternate every cycle so a host write never steals a refresh read
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      slot_q <= glyph_disp_pkg::SLOT_HOST;
    end else begin
      slot_q <= !slot_q;
    end
  end

  // One write is held until the next host slot; a pointer load in the same cycle wins
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      host_pend_q <= 1'b0;
      pend_data_q <= 8'h00;
    end else if (HOST_WE && HOST_READY && !HOST_PTR_WE) begin
      host_pend_q <= 1'b1;
      pend_data_q <= HOST_DATA;
    end else if (commit) begin
      host_pend_q <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      address_pointer_q <= 7'h00;
      ptr_glyph_q <= 1'b0;
    end else if (HOST_PTR_WE && HOST_READY) begin
      address_pointer_q <= HOST_PTR_GLYPH ? {1'b0, HOST_PTR_ADDR[5:0]} : HOST_PTR_ADDR;
      ptr_glyph_q <= HOST_PTR_GLYPH;
    end else if (commit) begin
      address_pointer_q <= ptr_glyph_q ? {1'b0, 6'(address_pointer_q[5:0] + 6'h01)}
                                       : 7'(address_pointer_q + 7'h01);
    end
  end

  // Geometry of the current scan
  assign line_base = (TWO_LINE && !FONT_TALL && row_q[3]) ? glyph_disp_pkg::LINE2_BASE
                                                          : glyph_disp_pkg::LINE1_BASE;
  assign text_addr = line_base | {2'b00, char_q};
  assign glyph_row = FONT_TALL ? row_q : {1'b0, row_q[2:0]};
  assign num_rows = FONT_TALL ? glyph_disp_pkg::ROWS_TALL
                  : (TWO_LINE ? glyph_disp_pkg::ROWS_TWO : glyph_disp_pkg::ROWS_SHORT);
  assign row_last = (5'({1'b0, row_q} + 5'h01) >= num_rows);
  assign cursor_row = FONT_TALL ? glyph_disp_pkg::CUR_ROW_TALL : glyph_disp_pkg::CUR_ROW_SHORT;

  // Tall: code bits 2:1 pick the pattern, bits 3 and 0 drop out
  assign glyph_addr = FONT_TALL ? {code_q[2:1], glyph_row}
                                : {code_q[2:0], glyph_row[2:0]};
  assign glyph_code = (code_q[7:4] == glyph_disp_pkg::GLYPH_PAGE);

  // Pointer compared whatever it targets, so a glyph target lands in the first line only
  assign at_cursor = (text_addr == address_pointer_q);
  assign src_dots = glyph_code ? glyph_q[4:0] : FONT_ROM_DATA;

  always_comb begin
    dots_d = DISPLAY_ON ? src_dots : glyph_disp_pkg::DOTS_NONE;
    if (DISPLAY_ON && CURSOR_ON && at_cursor && glyph_row == cursor_row) begin
      dots_d = dots_d | glyph_disp_pkg::DOTS_FULL;
    end
    if (DISPLAY_ON && BLINK_ON && at_cursor && blink_q) begin
      dots_d = glyph_disp_pkg::DOTS_FULL;
    end
  end

  // Memory ports: host owns the even slot, refresh the odd one
  assign text_bus.we = commit && !ptr_glyph_q;
  assign text_bus.addr = refresh_slot ? text_addr : address_pointer_q;
  assign text_bus.wdata = pend_data_q;
  assign glyph_bus.we = commit && ptr_glyph_q;
  assign glyph_bus.addr = refresh_slot ? glyph_addr : address_pointer_q[5:0];
  assign glyph_bus.wdata = pend_data_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= glyph_disp_pkg::ST_TEXT;
      char_q <= 5'h00;
      row_q <= 4'h0;
    end else if (refresh_slot) begin
      unique case (state_q)
        glyph_disp_pkg::ST_TEXT: begin
          state_q <= glyph_disp_pkg::ST_GLYPH;
        end
        glyph_disp_pkg::ST_GLYPH: begin
          state_q <= glyph_disp_pkg::ST_COMPOSE;
        end
        glyph_disp_pkg::ST_COMPOSE: begin
          if (char_q == glyph_disp_pkg::CHAR_LAST) begin
            state_q <= glyph_disp_pkg::ST_LATCH;
          end else begin
            char_q <= 5'(char_q + 5'h01);
            state_q <= glyph_disp_pkg::ST_TEXT;
          end
        end
        glyph_disp_pkg::ST_LATCH: begin
          char_q <= 5'h00;
          row_q <= row_last ? 4'h0 : 4'(row_q + 4'h1);
          state_q <= glyph_disp_pkg::ST_TEXT;
        end
      endcase
    end
  end

  // Read data land in the host slot after each refresh read
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      code_q <= 8'h00;
      glyph_q <= 8'h00;
    end else if (!refresh_slot && state_q == glyph_disp_pkg::ST_GLYPH) begin
      code_q <= text_bus.rdata;
    end else if (!refresh_slot && state_q == glyph_disp_pkg::ST_COMPOSE) begin
      glyph_q <= glyph_bus.rdata;
    end
  end

  // Font ROM gets its address two cycles before its data is used
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rom_addr_q <= 12'h000;
    end else if (refresh_slot && state_q == glyph_disp_pkg::ST_GLYPH) begin
      rom_addr_q <= {code_q, glyph_row};
    end
  end
  assign FONT_ROM_ADDR = rom_addr_q;

  // First character ends up in the top bits, its bit 4 at SEG[99]
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      row_buf_q <= '0;
    end else if (refresh_slot && state_q == glyph_disp_pkg::ST_COMPOSE) begin
      row_buf_q <= {row_buf_q[94:0], dots_d};
    end
  end

  // A stale row beyond the count after a mode change shows no common at all
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      seg_q <= '0;
      com_q <= 16'h0000;
    end else if (refresh_slot && state_q == glyph_disp_pkg::ST_LATCH) begin
      seg_q <= row_buf_q;
      com_q <= ({1'b0, row_q} < num_rows) ? 16'(16'h0001 << row_q) : 16'h0000;
    end
  end
  assign SEG = seg_q;
  assign COM = com_q;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      frame_cnt_q <= 8'h00;
      blink_q <= 1'b0;
    end else if (refresh_slot && state_q == glyph_disp_pkg::ST_LATCH && row_last) begin
      if (frame_cnt_q == 8'(BLINK_FRAMES - 1)) begin
        frame_cnt_q <= 8'h00;
        blink_q <= !blink_q;
      end else begin
        frame_cnt_q <= 8'(frame_cnt_q + 8'h01);
      end
    end
  end

  // Checks sleep during reset; the scan first steps on the second edge after it, the first being a host slot
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);

  slot_separation_a: assert property ((text_bus.we || glyph_bus.we) |-> !refresh_slot)
    else $error("memory written in a refresh slot");
  host_commit_bound_a: assert property (!HOST_READY |-> ##[1:2] HOST_READY)
    else $error("held host write not committed within two cycles");
  com_onehot_a: assert property ($onehot0(COM))
    else $error("more than one common selected");
  // Judged at the latch: a row already showing keeps its common through a mode change
  unused_com_a: assert property ((refresh_slot && state_q == glyph_disp_pkg::ST_LATCH)
      |=> (COM >> $past(num_rows)) == 16'h0000)
    else $error("common beyond the row count selected");
  // Judged against the glyph RAM read itself, not the source mux
  glyph_page_a: assert property ((refresh_slot && state_q == glyph_disp_pkg::ST_COMPOSE
      && DISPLAY_ON && !at_cursor && code_q[7:4] == 4'h0)
      |=> row_buf_q[4:0] == $past(glyph_bus.rdata[4:0], 2))
    else $error("glyph page code not taken from glyph RAM");
  tall_addr_a: assert property ((refresh_slot && FONT_TALL) |->
      glyph_bus.addr == {code_q[2:1], row_q})
    else $error("tall glyph address wrong");
  cursor_row_a: assert property ((refresh_slot && state_q == glyph_disp_pkg::ST_COMPOSE
      && DISPLAY_ON && CURSOR_ON && at_cursor && glyph_row == cursor_row)
      |=> row_buf_q[4:0] == 5'h1F)
    else $error("cursor row not fully lit at the pointer");
  stored_dots_a: assert property ((refresh_slot && state_q == glyph_disp_pkg::ST_COMPOSE
      && DISPLAY_ON) |=> (row_buf_q[4:0] & $past(src_dots)) == $past(src_dots))
    else $error("stored lit dot dropped");
  leftmost_dot_a: assert property ((refresh_slot && state_q == glyph_disp_pkg::ST_LATCH)
      |=> SEG == $past(row_buf_q))
    else $error("segment row not latched from composed row");
  // Blink lights the whole cell on every row, cursor or not
  blink_cell_a: assert property ((refresh_slot && state_q == glyph_disp_pkg::ST_COMPOSE
      && DISPLAY_ON && BLINK_ON && at_cursor && blink_q)
      |=> row_buf_q[4:0] == 5'h1F)
    else $error("blinking cell not fully lit");
  // A glyph-targeted pointer never leaves the 64-word glyph store
  glyph_ptr_a: assert property (ptr_glyph_q |-> !address_pointer_q[6])
    else $error("glyph pointer left its six-bit range");

  tall_glyph_c: cover property (refresh_slot && FONT_TALL && glyph_code
      && state_q == glyph_disp_pkg::ST_COMPOSE);
  cursor_hit_c: cover property (CURSOR_ON && at_cursor && glyph_row == cursor_row);
  host_commit_c: cover property (commit && ptr_glyph_q);
  frame_end_c: cover property (refresh_slot && state_q == glyph_disp_pkg::ST_LATCH && row_last);
  blink_lit_c: cover property (refresh_slot && BLINK_ON && at_cursor && blink_q);
endmodule
`default_nettype wire

// file: glyph_ram_tall_font_cursor_tb.sv
// Self-checking bench for the tall-font glyph display refresh block
`default_nettype none
module glyph_ram_tall_font_cursor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic CLK, RST_N, HOST_PTR_WE, HOST_PTR_GLYPH, HOST_WE, HOST_READY;
  logic [6:0] HOST_PTR_ADDR, HOST_PTR;
  logic [7:0] HOST_DATA;
  logic DISPLAY_ON, CURSOR_ON;
  logic FONT_TALL, TWO_LINE, BLINK_ON;
  logic [11:0] FONT_ROM_ADDR;
  logic [4:0] FONT_ROM_DATA;
  logic [15:0] COM;
  logic [99:0] SEG;
  logic [7:0] codes [20];
  int n_errors = 0;
  int comparisons = 0;
  int cycles = 0;

  glyph_disp_top #(.BLINK_FRAMES(2)) u_dut (
    .CLK(CLK), .RST_N(RST_N), .HOST_PTR_WE(HOST_PTR_WE),
    .HOST_PTR_GLYPH(HOST_PTR_GLYPH), .HOST_PTR_ADDR(HOST_PTR_ADDR),
    .HOST_WE(HOST_WE), .HOST_DATA(HOST_DATA), .HOST_READY(HOST_READY),
    .HOST_PTR(HOST_PTR), .FONT_TALL(FONT_TALL), .TWO_LINE(TWO_LINE),
    .DISPLAY_ON(DISPLAY_ON), .CURSOR_ON(CURSOR_ON), .BLINK_ON(BLINK_ON),
    .FONT_ROM_ADDR(FONT_ROM_ADDR), .FONT_ROM_DATA(FONT_ROM_DATA), .COM(COM), .SEG(SEG)
  );
  font_rom_model u_rom (.clk(CLK), .addr(FONT_ROM_ADDR), .data(FONT_ROM_DATA));

  initial begin
    CLK = 1'b0;
    forever #2 CLK = ~CLK;
  end

  task automatic wrap_up();
    if (n_errors == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // A hung handshake or a frozen scan must still end the run
  always @(posedge CLK) begin
    cycles++;
    if (cycles == 80000) begin
      n_errors++;
      wrap_up();
    end
  end

  task automatic check(input logic [99:0] seen, input logic [99:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] %0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Glyph bytes: upper bits set on purpose since they must not show
  function automatic logic [7:0] gdat(input logic [5:0] a);
    logic [4:0] low;
    low = a[4:0] ^ {a[5], 4'h6};
    if (a[3:0] == 4'hA) begin
      low = a[5] ? 5'h11 : 5'h00;
    end
    return {3'h5, low};
  endfunction

  task automatic wait_ready();
    int k;
    k = 0;
    while (HOST_READY !== 1'b1 && k < 20) begin
      @(negedge CLK);
      k++;
    end
  endtask

  task automatic set_ptr(input logic glyph, input logic [6:0] addr);
    wait_ready();
    HOST_PTR_WE = 1'b1;
    HOST_PTR_GLYPH = glyph;
    HOST_PTR_ADDR = addr;
    @(negedge CLK);
    HOST_PTR_WE = 1'b0;
    @(negedge CLK);
  endtask

  task automatic put(input logic [7:0] d);
    wait_ready();
    HOST_WE = 1'b1;
    HOST_DATA = d;
    @(negedge CLK);
    HOST_WE = 1'b0;
    @(negedge CLK);
  endtask

  // Skips one showing of row r so the next one was composed wholly after the
  // caller's last change; a row in flight would mix old and new settings
  task automatic await_row(input int r);
    int k;
    k = 0;
    while (COM !== 16'(16'h0001 << r) && k < 5000) begin
      @(negedge CLK);
      k++;
    end
    while (COM === 16'(16'h0001 << r) && k < 5000) begin
      @(negedge CLK);
      k++;
    end
    while (COM !== 16'(16'h0001 << r) && k < 5000) begin
      @(negedge CLK);
      k++;
    end
  endtask

  // Waits for a fresh scan of row r, then compares every dot of it
  task automatic show_row(input int r, input int cur);
    logic [99:0] exp;
    logic [4:0] d;
    logic [7:0] c;
    logic [7:0] g;
    logic [3:0] gr;
    await_row(r);
    gr = FONT_TALL ? r[3:0] : {1'b0, r[2:0]};
    for (int i = 0; i < 20; i++) begin
      c = codes[i];
      g = gdat(FONT_TALL ? {c[2:1], gr} : {c[2:0], gr[2:0]});
      d = c[7:4] == 4'h0 ? g[4:0] : {c[0], gr} ^ c[7:3];
      if (gr == (FONT_TALL ? 4'hA : 4'h7) && i == cur) begin
        d = d | 5'h1F;
      end
      exp[99 - 5 * i -: 5] = DISPLAY_ON ? d : 5'h00;
    end
    check(SEG, exp);
    check(COM, 16'(16'h0001 << r));
    check(COM >> (FONT_TALL ? 11 : 8), 100'h0);
  endtask

  task automatic load_glyphs();
    set_ptr(1'b1, 7'h10);
    for (int a = 16; a < 48; a++) begin
      put(gdat(a[5:0]));
    end
    wait_ready();
    check(HOST_PTR, 100'h30);
  endtask

  task automatic load_text();
    set_ptr(1'b0, 7'h00);
    for (int i = 0; i < 20; i++) begin
      put(codes[i]);
    end
    wait_ready();
    check(HOST_PTR, 100'h14);
  endtask

  task automatic full_frame();
    set_ptr(1'b0, 7'h00);
    for (int r = 0; r < 11; r++) begin
      show_row(r, 0);
    end
  endtask

  task automatic moved_cursor();
    set_ptr(1'b0, 7'h03);
    show_row(10, 3);
    // Bit 6 drops for a glyph target, so 42 lands on the third character
    set_ptr(1'b1, 7'h42);
    show_row(10, 2);
  endtask

  task automatic blank_display();
    DISPLAY_ON = 1'b0;
    show_row(4, -1);
    DISPLAY_ON = 1'b1;
  endtask

  task automatic short_font();
    FONT_TALL = 1'b0;
    set_ptr(1'b0, 7'h01);
    show_row(7, 1);
    show_row(3, -1);
    TWO_LINE = 1'b1;
    await_row(12);
    check(COM, 100'h1000);
    TWO_LINE = 1'b0;
    FONT_TALL = 1'b1;
  endtask

  // Six frames span a full blink period, so both phases must show
  task automatic blink_cursor();
    int lit;
    lit = 0;
    CURSOR_ON = 1'b0;
    BLINK_ON = 1'b1;
    set_ptr(1'b0, 7'h05);
    repeat (6) begin
      await_row(0);
      if (SEG[74 -: 5] === 5'h1F) begin
        lit++;
      end else begin
        // Code 41 on row 0 through the ROM stand-in
        check(SEG[74 -: 5], 100'h18);
      end
    end
    check(lit >= 2 && lit <= 4, 100'h1);
    BLINK_ON = 1'b0;
  endtask

  initial begin
    RST_N = 1'b0;
    HOST_PTR_WE = 1'b0;
    HOST_PTR_GLYPH = 1'b0;
    HOST_PTR_ADDR = 7'h00;
    HOST_WE = 1'b0;
    HOST_DATA = 8'h00;
    DISPLAY_ON = 1'b1;
    CURSOR_ON = 1'b1;
    FONT_TALL = 1'b1;
    TWO_LINE = 1'b0;
    BLINK_ON = 1'b0;
    // Codes 02/0B and 04/0D pair up to expose ignored code bits
    codes = '{8'h02, 8'h0B, 8'h04, 8'h0D, 8'h30, 8'h41, 8'h52, 8'h63, 8'h74, 8'h85,
              8'h96, 8'hA7, 8'hB8, 8'hC9, 8'hDA, 8'hEB, 8'hFC, 8'h1D, 8'h2E, 8'h3F};
    repeat (12) @(negedge CLK);
    RST_N = 1'b1;
    @(negedge CLK);
    load_glyphs();
    load_text();
    full_frame();
    moved_cursor();
    blank_display();
    short_font();
    blink_cursor();
    wrap_up();
  end
endmodule
`default_nettype wire
